// ### pkg/smpc_pkg.sv
package smpc_pkg;

    // time base and key timing
    localparam int unsigned CLK_HZ          = 200_000_000;
    localparam int unsigned TICK_MS         = 1;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned DEBOUNCE_MS     = 20;
    localparam int unsigned HOLD_MS         = 3000;
    localparam int unsigned BLINK_PERIOD_MS = 2000;
    localparam int unsigned BLINK_HALF_MS   = BLINK_PERIOD_MS / 2;

    // display geometry
    localparam int unsigned BAR_SEGS        = 51;
    localparam int unsigned BAR_PCT_STEP    = 2;
    localparam int unsigned BAR_FULL_PCT    = (BAR_SEGS - 1) * BAR_PCT_STEP;
    localparam int unsigned DECADE_BARS     = 5;
    localparam int unsigned DECADES         = 6;

    // key indices
    localparam int unsigned KEY_RESP        = 0;
    localparam int unsigned KEY_MODE        = 1;
    localparam int unsigned KEY_RATEINT     = 2;
    localparam int unsigned KEY_LOG         = 3;
    localparam int unsigned KEY_POWER       = 4;
    localparam int unsigned NKEYS           = 5;

    // unit mode indices
    localparam int unsigned NMODES          = 8;
    localparam logic [2:0]  MODE_CPM        = 3'h0;
    localparam logic [2:0]  MODE_CPS        = 3'h1;
    localparam logic [2:0]  MODE_EXPO       = 3'h2;
    localparam logic [2:0]  MODE_SURF_SI    = 3'h3;
    localparam logic [2:0]  MODE_SURF_CI    = 3'h4;
    localparam logic [2:0]  MODE_DPM        = 3'h5;
    localparam logic [2:0]  MODE_DOSE_EQ    = 3'h6;
    localparam logic [2:0]  MODE_ABS_DOSE   = 3'h7;
    localparam logic [7:0]  BASIC_MODES     = 8'h03;
    localparam logic [7:0]  SPECIAL_MODES   = 8'h38;

    // response times in seconds, index 0 first
    localparam logic [4:0]  RESP_S0         = 5'h18;
    localparam logic [4:0]  RESP_S1         = 5'h0C;
    localparam logic [4:0]  RESP_S2         = 5'h06;
    localparam logic [4:0]  RESP_S3         = 5'h03;

    typedef enum logic [3:0] {
        MSG_NONE     = 4'h0,
        MSG_RESP     = 4'h1,
        MSG_UNIT     = 4'h2,
        MSG_NOT_LOG  = 4'h3,
        MSG_MAN_RDY  = 4'h4,
        MSG_TIM_RDY  = 4'h5,
        MSG_LOC_LBL  = 4'h6,
        MSG_LOC_ID   = 4'h7,
        MSG_INT_CLR  = 4'h8
    } smpc_msg_t;

    typedef enum logic [1:0] {
        LOG_MANUAL     = 2'h0,
        LOG_MANUAL_LOC = 2'h1,
        LOG_TIMED      = 2'h2,
        LOG_TIMED_LOC  = 2'h3
    } smpc_logmode_t;

    // per-key debounce / hold tracker, gray-coded path idle-press-held
    typedef enum logic [1:0] {
        KS_IDLE  = 2'b00,
        KS_PRESS = 2'b01,
        KS_HELD  = 2'b11
    } smpc_kstate_t;

    typedef struct packed {
        logic [NKEYS-1:0] lock;
        logic [7:0]       mode_en;
        logic [2:0]       default_mode;
        logic             probe_cal;
        logic             special_cal;
        logic             int_reset_en;
        logic             rate_int_fixed;
        logic             log_enable;
        smpc_logmode_t    log_mode;
        logic [15:0]      log_interval_s;
    } smpc_cfg_t;

    typedef struct packed {
        logic [6:0] level_pct;
        logic [2:0] decade;
        logic       alarm;
        logic       data_retrieved;
    } smpc_meas_t;

    typedef struct packed {
        logic [BAR_SEGS-1:0]    bar;
        logic [DECADE_BARS-1:0] decade_bars;
        logic                   blank;
    } smpc_disp_t;

    typedef struct packed {
        smpc_msg_t  msg;
        logic       msg_stb;
        logic [2:0] unit_mode;
        logic [1:0] resp_idx;
        logic [4:0] resp_s;
        logic       show_integ;
        logic       log_active;
        logic       log_store;
        logic       int_clear;
        logic       power_off;
        logic       loc_label_stb;
        logic       loc_id_stb;
    } smpc_stat_t;

endpackage

// ### rtl/smpc_panel.sv
`timescale 1ns/1ps
// Functional notes
// - bargraph of 51 segments, each two percent of the span
// - one to five decade bars; sixth decade lights all five
// - alarm blinks the whole display with a two second period
// - response key advances response time and reports it
// - response times 24, 12, 6 and 3 seconds in rotation
// - configuration can lock keys so presses have no effect
// - integrate mode: three second response hold clears integrate values
// - a flag can disable the integrate clear on long hold
// - default unit mode is the configured one, else the first allowed mode
// - unit key selects next enabled mode and shows its name
// - eight unit modes in order, disabled ones skipped
// - uncalibrated probe allows only counts per minute and second
// - surface activity and dpm modes need special calibration
// - at least one mode always stays enabled: with none left, the default mode, or cpm if uncalibrated
// - rate-integral key toggles rate versus integrated display
// - locked rate-integral key keeps the configured display mode
// - logging is inactive at power-up; only the tool activates it
// - log press with logging off stores nothing, shows a message
// - power key ignored while logging until data retrieved
// - manual or timed logging, with or without locations
// - manual logging: log press stores data and shows ready
// - timed logging stores at the configured interval, shows ready
// - with locations, three second log hold changes the label
module smpc_panel
    import smpc_pkg::*;
#(
    parameter int unsigned TICK_CYC  = TICK_CYCLES,
    parameter int unsigned DEB_TICKS = DEBOUNCE_MS,
    parameter int unsigned HOLD_TICK = HOLD_MS,
    parameter int unsigned BLNK_TICK = BLINK_HALF_MS,
    parameter int unsigned SEC_TICKS = 1000
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic [NKEYS-1:0] key_pin_n,
    input  wire smpc_pkg::smpc_cfg_t  cfg,
    input  wire smpc_pkg::smpc_meas_t meas,
    input  wire logic             log_activate,
    output smpc_pkg::smpc_disp_t  disp,
    output smpc_pkg::smpc_stat_t  stat
);
    import smpc_pkg::*;

    localparam int unsigned TW = $clog2(TICK_CYC + 1);
    localparam int unsigned HW = $clog2(HOLD_TICK + 1);
    localparam int unsigned BW = $clog2(BLNK_TICK + 1);
    localparam int unsigned SW = $clog2(SEC_TICKS + 1);

    // fixed encodings used by the mode mask and the interval count
    localparam logic [7:0]  NO_MODE  = 8'h00;
    localparam logic [7:0]  ONE_MODE = 8'h01;
    localparam logic [15:0] ONE_SEC  = 16'h0001;

    typedef struct packed {
        logic [NKEYS-1:0]         sync1;
        logic [NKEYS-1:0]         sync2;
        smpc_kstate_t [NKEYS-1:0] ks;
        logic [NKEYS-1:0][HW-1:0] kcnt;
        logic [TW-1:0]            tick_cnt;
        logic [BW-1:0]            blink_cnt;
        logic                     blink_off;
        logic [SW-1:0]            sec_cnt;
        logic [15:0]              log_secs;
        logic                     started;
        smpc_disp_t               disp;
        smpc_stat_t               stat;
    } smpc_state_t;

    smpc_state_t st_r;
    smpc_state_t st_nxt;

    // modes permitted by configuration and calibration
    function automatic logic [7:0] allowed_modes(input smpc_cfg_t c);
        logic [7:0] m;
        m = c.mode_en;
        if (!c.probe_cal) begin
            m = m & BASIC_MODES;
        end
        if (!c.special_cal) begin
            m = m & ~SPECIAL_MODES;
        end
        if (m == NO_MODE) begin
            m = ONE_MODE << c.default_mode;
            if (!c.probe_cal) begin
                m = ONE_MODE << MODE_CPM;
            end
        end
        return m;
    endfunction

    // next enabled mode after cur, wrapping
    function automatic logic [2:0] next_mode(input logic [2:0] cur, input logic [7:0] m);
        logic [2:0] r;
        logic       found;
        logic [2:0] idx;
        r = cur;
        found = 1'b0;
        for (int i = 1; i <= NMODES; i++) begin
            idx = 3'(cur + 3'(i));
            if (!found && m[idx]) begin
                r = idx;
                found = 1'b1;
            end
        end
        return r;
    endfunction

    function automatic logic [4:0] resp_secs(input logic [1:0] i);
        case (i)
            2'h0:    return RESP_S0;
            2'h1:    return RESP_S1;
            2'h2:    return RESP_S2;
            default: return RESP_S3;
        endcase
    endfunction

    logic             tick;
    logic [NKEYS-1:0] short_evt;
    logic [NKEYS-1:0] hold_evt;
    logic [7:0]       allow;
    logic [NKEYS-1:0] pressed;

    // one tick drives all key, blink and log timing
    assign tick  = (st_r.tick_cnt == TW'(TICK_CYC - 1));
    assign allow = allowed_modes(cfg);
    // pins are active low; inverted only after the second flop
    assign pressed = ~st_r.sync2;

    always_comb begin
        st_nxt = st_r;
        st_nxt.stat.msg_stb       = 1'b0;
        st_nxt.stat.log_store     = 1'b0;
        st_nxt.stat.int_clear     = 1'b0;
        st_nxt.stat.power_off     = 1'b0;
        st_nxt.stat.loc_label_stb = 1'b0;
        st_nxt.stat.loc_id_stb    = 1'b0;
        short_evt = '0;
        hold_evt  = '0;

        st_nxt.sync1 = key_pin_n;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.tick_cnt = tick ? '0 : TW'(st_r.tick_cnt + 1'b1);

        for (int k = 0; k < NKEYS; k++) begin
            case (st_r.ks[k])
                KS_IDLE: begin
                    if (!pressed[k]) begin
                        st_nxt.kcnt[k] = '0;
                    end else if (tick) begin
                        st_nxt.kcnt[k] = HW'(st_r.kcnt[k] + 1'b1);
                        if (st_r.kcnt[k] == HW'(DEB_TICKS - 1)) begin
                            st_nxt.ks[k] = KS_PRESS;
                        end
                    end
                end
                KS_PRESS: begin
                    if (!pressed[k]) begin
                        short_evt[k] = 1'b1;
                        st_nxt.ks[k] = KS_IDLE;
                        st_nxt.kcnt[k] = '0;
                    end else if (tick) begin
                        st_nxt.kcnt[k] = HW'(st_r.kcnt[k] + 1'b1);
                        if (st_r.kcnt[k] == HW'(HOLD_TICK - 1)) begin
                            hold_evt[k] = 1'b1;
                            st_nxt.ks[k] = KS_HELD;
                        end
                    end
                end
                default: begin
                    if (!pressed[k]) begin
                        st_nxt.ks[k] = KS_IDLE;
                        st_nxt.kcnt[k] = '0;
                    end
                end
            endcase
        end
        short_evt = short_evt & ~cfg.lock;
        hold_evt  = hold_evt & ~cfg.lock;

        // first cycle after reset takes configured defaults
        if (!st_r.started) begin
            st_nxt.started = 1'b1;
            st_nxt.stat.unit_mode = allow[cfg.default_mode] ? cfg.default_mode
                                                            : next_mode(MODE_ABS_DOSE, allow);
            st_nxt.stat.show_integ = 1'b0;
        end

        // keep unit mode legal if calibration state changes
        if (st_r.started && !allow[st_r.stat.unit_mode]) begin
            st_nxt.stat.unit_mode = next_mode(st_r.stat.unit_mode, allow);
        end

        if (short_evt[KEY_RESP]) begin
            st_nxt.stat.resp_idx = st_r.stat.resp_idx + 2'h1;
            st_nxt.stat.resp_s   = resp_secs(st_r.stat.resp_idx + 2'h1);
            st_nxt.stat.msg      = MSG_RESP;
            st_nxt.stat.msg_stb  = 1'b1;
        end
        // a hold gives no short event, so it never steps the response time
        // long hold clears integrate
        if (hold_evt[KEY_RESP] && st_r.stat.show_integ && cfg.int_reset_en) begin
            st_nxt.stat.int_clear = 1'b1;
            st_nxt.stat.msg       = MSG_INT_CLR;
            st_nxt.stat.msg_stb   = 1'b1;
        end

        if (short_evt[KEY_MODE]) begin
            st_nxt.stat.unit_mode = next_mode(st_r.stat.unit_mode, allow);
            st_nxt.stat.msg       = MSG_UNIT;
            st_nxt.stat.msg_stb   = 1'b1;
        end

        if (short_evt[KEY_RATEINT] && !cfg.rate_int_fixed) begin
            st_nxt.stat.show_integ = ~st_r.stat.show_integ;
        end

        if (log_activate && cfg.log_enable) begin
            st_nxt.stat.log_active = 1'b1;
        end else if (meas.data_retrieved) begin
            st_nxt.stat.log_active = 1'b0;
        end

        if (short_evt[KEY_LOG]) begin
            st_nxt.stat.msg_stb = 1'b1;
            if (!st_r.stat.log_active) begin
                st_nxt.stat.msg = MSG_NOT_LOG;
            end else begin
                case (cfg.log_mode)
                    LOG_MANUAL: begin
                        st_nxt.stat.log_store = 1'b1;
                        st_nxt.stat.msg       = MSG_MAN_RDY;
                    end
                    LOG_MANUAL_LOC: begin
                        st_nxt.stat.log_store = 1'b1;
                        st_nxt.stat.msg       = MSG_MAN_RDY;
                    end
                    default: begin
                        // timed modes: short press steps the location id
                        st_nxt.stat.loc_id_stb = 1'b1;
                        st_nxt.stat.msg        = MSG_LOC_ID;
                    end
                endcase
            end
        end
        if (hold_evt[KEY_LOG] && st_r.stat.log_active
            && (cfg.log_mode == LOG_MANUAL_LOC || cfg.log_mode == LOG_TIMED_LOC)) begin
            st_nxt.stat.loc_label_stb = 1'b1;
            st_nxt.stat.msg           = MSG_LOC_LBL;
            st_nxt.stat.msg_stb       = 1'b1;
        end

        // a second is SEC_TICKS ticks; the interval counts whole seconds
        // timed store on interval
        if (st_r.stat.log_active && cfg.log_mode[1]) begin
            if (tick) begin
                st_nxt.sec_cnt = (st_r.sec_cnt == SW'(SEC_TICKS - 1)) ? '0
                                                                   : SW'(st_r.sec_cnt + 1'b1);
                if (st_r.sec_cnt == SW'(SEC_TICKS - 1)) begin
                    st_nxt.log_secs = st_r.log_secs + ONE_SEC;
                    if (st_r.log_secs + ONE_SEC >= cfg.log_interval_s) begin
                        st_nxt.log_secs       = 16'h0000;
                        st_nxt.stat.log_store = 1'b1;
                        st_nxt.stat.msg       = MSG_TIM_RDY;
                        st_nxt.stat.msg_stb   = 1'b1;
                    end
                end
            end
        end else begin
            st_nxt.sec_cnt  = '0;
            st_nxt.log_secs = 16'h0000;
        end

        if (short_evt[KEY_POWER] && !st_r.stat.log_active) begin
            st_nxt.stat.power_off = 1'b1;
        end

        // alarm blink, half period each phase
        if (meas.alarm) begin
            if (tick) begin
                if (st_r.blink_cnt == BW'(BLNK_TICK - 1)) begin
                    st_nxt.blink_cnt = '0;
                    st_nxt.blink_off = ~st_r.blink_off;
                end else begin
                    st_nxt.blink_cnt = BW'(st_r.blink_cnt + 1'b1);
                end
            end
        end else begin
            st_nxt.blink_cnt = '0;
            st_nxt.blink_off = 1'b0;
        end
        st_nxt.disp.blank = st_nxt.blink_off;

        // bar segment i lit when level >= i*2 percent
        for (int i = 0; i < BAR_SEGS; i++) begin
            st_nxt.disp.bar[i] = (32'(meas.level_pct) >= 32'(i * BAR_PCT_STEP))
                                 && (i == 0 || meas.level_pct != 7'h00);
        end
        // decade bars, sixth decade all lit
        for (int d = 0; d < DECADE_BARS; d++) begin
            st_nxt.disp.decade_bars[d] = (32'(meas.decade) > 32'(d));
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.stat.resp_s <= RESP_S0;
            // released level, so leaving reset never looks like a press
            st_r.sync1 <= '1;
            st_r.sync2 <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs come straight from the state register
    assign disp = st_r.disp;
    assign stat = st_r.stat;

endmodule

// ### test/smpc_operator.sv
`timescale 1ns/1ps
module smpc_operator
    import smpc_pkg::*;
#(
    parameter int unsigned TICK_CYC = 4
) (
    input  wire logic        clock,
    output logic [NKEYS-1:0] key_pin_n
);
    // released keys read high through the panel pull-ups
    initial key_pin_n = '1;

    // a press is a clean low level of a whole number of ticks
    task automatic press(input int k, input int ticks);
        @(negedge clock);
        key_pin_n[k] = 1'b0;
        repeat (ticks * TICK_CYC) @(negedge clock);
        key_pin_n[k] = 1'b1;
    endtask
endmodule

// ### test/smpc_panel_monitor.sv
`timescale 1ns/1ps
module smpc_panel_monitor
    import smpc_pkg::*;
#(
    parameter int unsigned TICK_CYC  = TICK_CYCLES,
    parameter int unsigned BLNK_TICK = BLINK_HALF_MS
) (
    input wire logic                 clock,
    input wire logic                 resetn,
    input wire logic [NKEYS-1:0]     key_pin_n,
    input wire smpc_pkg::smpc_cfg_t  cfg,
    input wire smpc_pkg::smpc_meas_t meas,
    input wire logic                 log_activate,
    input wire smpc_pkg::smpc_disp_t disp,
    input wire smpc_pkg::smpc_stat_t stat
);
    // cycles since the last blank toggle seen while the alarm stays up;
    // a counter, because a half period is far too long for a repetition
    localparam int HALF_CYC = BLNK_TICK * TICK_CYC;
    logic        blank_q;
    logic        blink_seen;
    logic [31:0] blink_run;

    always_ff @(posedge clock) begin
        blank_q <= disp.blank;
        if (!resetn || !meas.alarm) begin
            blink_seen <= 1'b0;
            blink_run  <= 32'h0000_0000;
        end else if (disp.blank != blank_q) begin
            blink_seen <= 1'b1;
            blink_run  <= 32'h0000_0000;
        end else begin
            blink_run <= blink_run + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    a_bar_span:
        assert property ($past(resetn) |-> disp.bar[25] == ($past(meas.level_pct) >= 7'h32)
            && disp.bar[50] == ($past(meas.level_pct) >= 7'h64))
        else $error("bar segment does not follow level");
    a_decade_map:
        assert property ($past(resetn) |-> disp.decade_bars == (($past(meas.decade) >= 3'h5)
            ? 5'h1F : 5'h1F >> (3'h5 - $past(meas.decade))))
        else $error("decade bars wrong");
    a_blank_quiet:
        assert property (!$past(meas.alarm) && !$past(meas.alarm, 2) |-> !disp.blank)
        else $error("display blanked without alarm");
    a_blink_half:
        assert property (meas.alarm && blink_seen |-> ($changed(disp.blank)
            ? blink_run == HALF_CYC - 1 : blink_run < HALF_CYC - 1))
        else $error("blink half period wrong");
    a_resp_table:
        assert property (stat.resp_s == ((stat.resp_idx == 2'h0) ? RESP_S0 :
            (stat.resp_idx == 2'h1) ? RESP_S1 : (stat.resp_idx == 2'h2) ? RESP_S2 : RESP_S3))
        else $error("response seconds do not match index");
    a_resp_report:
        assert property ($changed(stat.resp_idx) |-> stat.msg_stb && stat.msg == MSG_RESP)
        else $error("response change without message");
    a_unit_report:
        assert property ($changed(stat.unit_mode) && $past(resetn, 2)
            |-> stat.msg_stb && stat.msg == MSG_UNIT)
        else $error("unit change without message");
    a_unit_allowed:
        assert property ($past(resetn) |-> (cfg.probe_cal || stat.unit_mode <= MODE_CPS)
            && (cfg.special_cal || !SPECIAL_MODES[stat.unit_mode]))
        else $error("unit mode not available");
    a_int_clear_gate:
        assert property (stat.int_clear |-> $past(stat.show_integ) && cfg.int_reset_en
            && $stable(stat.resp_idx))
        else $error("integrate clear not allowed");
    a_power_gate:
        assert property (stat.power_off |-> !$past(stat.log_active))
        else $error("power off while logging");
    a_store_gate:
        assert property (stat.log_store |-> $past(stat.log_active))
        else $error("store while logging inactive");
    a_ri_lock:
        assert property ($changed(stat.show_integ) && $past(resetn, 2)
            |-> !cfg.lock[KEY_RATEINT] && !cfg.rate_int_fixed)
        else $error("display mode changed while fixed");
endmodule

bind smpc_panel smpc_panel_monitor #(.TICK_CYC(TICK_CYC), .BLNK_TICK(BLNK_TICK)) u_mon (
    .clock(clock), .resetn(resetn), .key_pin_n(key_pin_n), .cfg(cfg), .meas(meas),
    .log_activate(log_activate), .disp(disp), .stat(stat));

// ### test/smpc_panel_tb_top.sv
`timescale 1ns/1ps
module smpc_panel_tb_top;
    import smpc_pkg::*;
    logic             clock = 1'b0;
    logic             resetn = 1'b0;
    logic [NKEYS-1:0] key_pin_n;
    smpc_cfg_t        cfg;
    smpc_cfg_t        base;
    smpc_cfg_t        c;
    smpc_meas_t       meas;
    logic             log_activate = 1'b0;
    smpc_disp_t       disp;
    smpc_stat_t       stat;
    int               errors = 0;
    int               cmp_count = 0;
    int               n;
    logic [4:0]       rt [4] = '{RESP_S1, RESP_S2, RESP_S3, RESP_S0};

    always #2.5 clock = ~clock;

    smpc_panel #(.TICK_CYC(4), .DEB_TICKS(2), .HOLD_TICK(10), .BLNK_TICK(5), .SEC_TICKS(3)) u_dut (
        .clock(clock), .resetn(resetn), .key_pin_n(key_pin_n), .cfg(cfg), .meas(meas),
        .log_activate(log_activate), .disp(disp), .stat(stat));
    // the operator's default tick length already matches the 4-cycle tick above
    smpc_operator u_op (.clock(clock), .key_pin_n(key_pin_n));

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic rst(input smpc_cfg_t cv);
        cfg = cv;
        resetn = 1'b0;
        repeat (16) @(negedge clock);
        resetn = 1'b1;
        repeat (3) @(negedge clock);
    endtask

    // em of F means the message code is not judged
    task automatic key(input int k, input int t, input logic [3:0] em, input logic [4:0] ep);
        logic [3:0] m;
        logic [4:0] p;
        m = MSG_NONE;
        p = '0;
        fork
            u_op.press(k, t);
            repeat (t * 4 + 30) begin
                @(negedge clock);
                if (stat.msg_stb === 1'b1) m = stat.msg;
                p = p | {stat.log_store, stat.int_clear, stat.power_off,
                         stat.loc_label_stb, stat.loc_id_stb};
            end
        join
        if (em !== 4'hF) chk("msg", m, em);
        chk("pulses", p, ep);
    endtask

    task automatic unit_walk(input smpc_cfg_t cv, input logic [31:0] seq, input int cnt);
        rst(cv);
        for (int j = 0; j < cnt; j++) begin
            key(KEY_MODE, 5, MSG_UNIT, 5'h00);
            chk("unit", stat.unit_mode, seq[4*j +: 3]);
        end
    endtask

    // blk selects a blank toggle, otherwise a store pulse
    task automatic wait_ev(input bit blk, output int cyc);
        logic b;
        b = disp.blank;
        cyc = 0;
        do begin
            @(negedge clock);
            cyc++;
        end while ((blk ? disp.blank === b : stat.log_store !== 1'b1) && cyc < 300);
        if (cyc >= 300) begin
            errors++;
            final_report();
        end
    endtask

    task automatic pulse_in(input bit retrieve);
        if (retrieve) meas.data_retrieved = 1'b1;
        else log_activate = 1'b1;
        @(negedge clock);
        meas.data_retrieved = 1'b0;
        log_activate = 1'b0;
        repeat (2) @(negedge clock);
    endtask

    initial begin
        base = '0;
        base.mode_en = 8'hFF;
        base.probe_cal = 1'b1;
        base.special_cal = 1'b1;
        base.int_reset_en = 1'b1;
        base.log_enable = 1'b1;
        base.log_interval_s = 16'h0002;
        meas = '0;
        rst(base);
        chk("unit", stat.unit_mode, MODE_CPM);
        chk("log", stat.log_active, 1'b0);
        for (int i = 0; i <= 100; i += 5) begin
            meas.level_pct = 7'(i);
            meas.decade = 3'(i % 7);
            repeat (2) @(negedge clock);
            chk("bar", disp.bar, (64'h1 << (i / 2 + 1)) - 64'h1);
            chk("decade", disp.decade_bars, (i % 7 >= 5) ? 5'h1F : 5'h1F >> (5 - i % 7));
        end
        for (int j = 0; j < 4; j++) begin
            key(KEY_RESP, 5, MSG_RESP, 5'h00);
            chk("resp", stat.resp_s, rt[j]);
        end
        key(KEY_RESP, 1, MSG_NONE, 5'h00);
        c = base;
        c.mode_en = 8'hC5;
        unit_walk(c, 32'h0762, 2);
        c = base;
        c.probe_cal = 1'b0;
        unit_walk(c, 32'h0001, 2);
        c = base;
        c.special_cal = 1'b0;
        unit_walk(c, 32'h07621, 5);
        c = base;
        c.mode_en = 8'h00;
        c.default_mode = MODE_EXPO;
        unit_walk(c, 32'h00000002, 1);
        c = base;
        c.lock = 5'h1B;
        c.rate_int_fixed = 1'b1;
        rst(c);
        key(KEY_RESP, 5, MSG_NONE, 5'h00);
        key(KEY_MODE, 5, MSG_NONE, 5'h00);
        key(KEY_POWER, 5, 4'hF, 5'h00);
        key(KEY_RATEINT, 5, 4'hF, 5'h00);
        chk("integ", stat.show_integ, 1'b0);
        rst(base);
        key(KEY_RESP, 14, 4'hF, 5'h00);
        key(KEY_RATEINT, 5, 4'hF, 5'h00);
        chk("integ", stat.show_integ, 1'b1);
        key(KEY_RESP, 14, 4'hF, 5'h08);
        chk("resp", stat.resp_s, RESP_S0);
        key(KEY_RATEINT, 5, 4'hF, 5'h00);
        chk("integ", stat.show_integ, 1'b0);
        c = base;
        c.int_reset_en = 1'b0;
        rst(c);
        key(KEY_RATEINT, 5, 4'hF, 5'h00);
        key(KEY_RESP, 14, 4'hF, 5'h00);
        c = base;
        c.log_mode = LOG_MANUAL_LOC;
        rst(c);
        key(KEY_LOG, 5, MSG_NOT_LOG, 5'h00);
        pulse_in(1'b0);
        chk("log", stat.log_active, 1'b1);
        key(KEY_LOG, 5, MSG_MAN_RDY, 5'h10);
        key(KEY_LOG, 14, 4'hF, 5'h02);
        key(KEY_POWER, 5, 4'hF, 5'h00);
        pulse_in(1'b1);
        chk("log", stat.log_active, 1'b0);
        key(KEY_POWER, 5, 4'hF, 5'h04);
        key(KEY_LOG, 14, 4'hF, 5'h00);
        c.log_mode = LOG_TIMED_LOC;
        c.log_interval_s = 16'h00FF;
        rst(c);
        pulse_in(1'b0);
        key(KEY_LOG, 5, MSG_LOC_ID, 5'h01);
        key(KEY_LOG, 14, MSG_LOC_LBL, 5'h02);
        c.log_mode = LOG_TIMED;
        c.log_interval_s = 16'h0002;
        rst(c);
        pulse_in(1'b0);
        wait_ev(1'b0, n);
        chk("msg", stat.msg, MSG_TIM_RDY);
        wait_ev(1'b0, n);
        chk("interval", n, 2 * 3 * 4);
        meas.alarm = 1'b1;
        wait_ev(1'b1, n);
        wait_ev(1'b1, n);
        chk("blink", n, 5 * 4);
        repeat (10) @(negedge clock);
        meas.alarm = 1'b0;
        repeat (3) @(negedge clock);
        chk("blank", disp.blank, 1'b0);
        final_report();
    end
endmodule
